// File: drf_core_model.sv
// Behavioural model of the core datapath that drives the register file
`timescale 1ns/1ns
module drf_core_model
(
  input  wire logic            clk,
  output drf_pkg::drf_req_t     req,
  output drf_pkg::drf_core_ctl_t ctl,
  output drf_pkg::drf_cfg_t     cfg,
  input  wire drf_pkg::drf_rsp_t rsp
);
  import drf_pkg::*;
  initial
  begin
    req = '0;
    ctl = '0;
    cfg = '0;
  end
  // Missing answer reads as unknown so the caller's compare fails
  task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    req = '{1'b1, wr, a, d};
    @(negedge clk);
    req = '0;
    q = rsp.valid ? rsp.data : 8'hXX;
  endtask
  task automatic config_write(input logic tris, input logic [1:0] sel, input logic opt, input logic [7:0] d);
    @(negedge clk);
    cfg = '{tris, sel, opt, d};
    @(negedge clk);
    cfg = '0;
  endtask
  // Status write and ALU flag strobe in one cycle, to exercise their priority
  task automatic flag_write(input logic [2:0] f, input logic [4:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{1'b1, 1'b1, a, d};
    ctl = '{1'b0, 1'b1, f[2], f[1], f[0]};
    @(negedge clk);
    req = '0;
    ctl = '0;
  endtask
  task automatic pc_step();
    @(negedge clk);
    ctl.pc_inc = 1'b1;
    @(negedge clk);
    ctl = '0;
  endtask
endmodule

// File: drf_pkg.sv
// Constants and carrier types for the data memory register file
package drf_pkg;

  // Variant selection: sizes of the special and general groups and banking
  typedef enum logic [1:0] {
    DRF_VAR_SMALL,
    DRF_VAR_PORTC,
    DRF_VAR_LARGE_PORTC,
    DRF_VAR_LARGE
  } drf_variant_t;

  localparam int DATA_W       = 8;
  localparam int ADDR_W       = 5;
  localparam int PORT_A_W     = 4;
  localparam int BANK_W       = 2;
  localparam int SLOT_W       = 7;

  // Direct address map of the register file
  localparam logic [ADDR_W-1:0] ADR_INDIRECT = 5'h00;
  localparam logic [ADDR_W-1:0] ADR_TIMER    = 5'h01;
  localparam logic [ADDR_W-1:0] ADR_PCL      = 5'h02;
  localparam logic [ADDR_W-1:0] ADR_STATUS   = 5'h03;
  localparam logic [ADDR_W-1:0] ADR_POINTER  = 5'h04;
  localparam logic [ADDR_W-1:0] ADR_PORT_A   = 5'h05;
  localparam logic [ADDR_W-1:0] ADR_PORT_B   = 5'h06;
  localparam logic [ADDR_W-1:0] ADR_PORT_C   = 5'h07;
  localparam logic [ADDR_W-1:0] ADR_BANK_LO  = 5'h10;

  // Group sizes per variant
  localparam int SFR_SMALL    = 7;
  localparam int GPR_SMALL    = 25;
  localparam int SFR_PORTC    = 8;
  localparam int GPR_PORTC    = 24;
  localparam int BANKED_GPR   = 48;
  localparam int BANK_SIZE    = 16;
  localparam int GPR_SLOTS    = GPR_SMALL + BANKED_GPR;

  // Pointer layout: bank select bits and bits that are not implemented
  localparam int PTR_BANK_LSB = 5;
  localparam logic [DATA_W-1:0] PTR_FIXED_SMALL = 8'hE0;
  localparam logic [DATA_W-1:0] PTR_FIXED_LARGE = 8'h80;

  // Status bit positions and writable mask
  localparam int ST_C  = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z  = 2;
  localparam logic [DATA_W-1:0] ST_SW_MASK = 8'hE7;
  localparam logic [DATA_W-1:0] ST_FLAG_MASK = 8'h07;

  // Option bit positions
  localparam int OPT_EDGE = 4;
  localparam int OPT_SRC  = 5;

  // Reset values
  localparam logic [DATA_W-1:0] STATUS_RST  = 8'h18;
  localparam logic [DATA_W-1:0] OPTION_RST  = 8'hFF;
  localparam logic [DATA_W-1:0] TRIS_RST    = 8'hFF;
  localparam logic [DATA_W-1:0] PCL_RST     = 8'hFF;
  localparam logic [DATA_W-1:0] POINTER_RST = 8'h00;
  localparam logic [DATA_W-1:0] TIMER_RST   = 8'h00;

  // Cycle rate divider: one instruction cycle is four oscillator periods
  localparam int CLK_DIV = 4;
  localparam logic [1:0] DIV_LAST = 2'(CLK_DIV - 1);
  localparam int CLKOUT_BIT = 1;

  // Port select for direction writes
  localparam logic [1:0] SEL_PORT_A = 2'h1;
  localparam logic [1:0] SEL_PORT_B = 2'h2;
  localparam logic [1:0] SEL_PORT_C = 2'h3;

  typedef struct packed {
    logic              valid;
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } drf_req_t;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } drf_rsp_t;

  typedef struct packed {
    logic pc_inc;
    logic flags_we;
    logic z;
    logic dc;
    logic c;
  } drf_core_ctl_t;

  typedef struct packed {
    logic              tris_we;
    logic [1:0]        tris_sel;
    logic              option_we;
    logic [DATA_W-1:0] wdata;
  } drf_cfg_t;

endpackage

// File: drf_properties.sv
// Concurrent checks on the register file ports
`timescale 1ns/1ns
module drf_properties
#(
  parameter drf_pkg::drf_variant_t VARIANT = drf_pkg::DRF_VAR_SMALL
)
(
  input wire logic                   CLK,
  input wire logic                   RST,
  input wire logic                   MASTER_CLEAR_N,
  input wire logic                   RC_MODE,
  input wire logic                   CYCLE_RATE_CLOCK_OUTPUT,
  input wire logic                   CYCLE_ENABLE,
  input wire drf_pkg::drf_req_t      CORE_REQ,
  input wire drf_pkg::drf_core_ctl_t CORE_CTL,
  input wire drf_pkg::drf_cfg_t      CORE_CFG,
  input wire drf_pkg::drf_rsp_t      CORE_RSP,
  input wire logic [7:0]             PROGRAM_COUNTER_LOW,
  input wire logic [7:0]             OPTION_OUT,
  input wire logic [7:0]             STATUS_OUT,
  input wire logic [7:0]             PORT_B_OE,
  input wire logic [7:0]             PORT_C_OUT,
  input wire logic [7:0]             PORT_C_OE
);
  import drf_pkg::*;
  // Master clear history; conservative so the two sync flops are surely settled
  logic [2:0] master_clear_n_q;
  logic       rd_q;
  logic       live;
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      master_clear_n_q <= 3'h0;
      rd_q   <= 1'b0;
    end
    else
    begin
      master_clear_n_q <= {master_clear_n_q[1:0], MASTER_CLEAR_N};
      rd_q   <= CORE_REQ.valid & ~CORE_REQ.write;
    end
  end
  assign live = MASTER_CLEAR_N & (&master_clear_n_q);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_read_answer: assert property (live && CORE_REQ.valid && !CORE_REQ.write |=> CORE_RSP.valid)
    else $error("read request got no answer");
  a_answer_cause: assert property (CORE_RSP.valid |-> rd_q)
    else $error("answer without a read");
  a_enable_period: assert property (CYCLE_ENABLE |=> !CYCLE_ENABLE [*3] ##1 CYCLE_ENABLE)
    else $error("cycle enable not every fourth clock");
  a_clkout_shape: assert property (RC_MODE [*4] ##0 $rose(CYCLE_RATE_CLOCK_OUTPUT) |=>
    CYCLE_RATE_CLOCK_OUTPUT ##1 !CYCLE_RATE_CLOCK_OUTPUT [*2] ##1 CYCLE_RATE_CLOCK_OUTPUT)
    else $error("clock output not a quarter rate");
  a_clkout_off: assert property (!RC_MODE [*2] |-> !CYCLE_RATE_CLOCK_OUTPUT)
    else $error("clock output runs outside RC mode");
  a_tris_write: assert property (live && CORE_CFG.tris_we && CORE_CFG.tris_sel == SEL_PORT_B |=>
    PORT_B_OE == ~$past(CORE_CFG.wdata))
    else $error("direction write not applied");
  a_option_write: assert property (live && CORE_CFG.option_we |=> OPTION_OUT == $past(CORE_CFG.wdata))
    else $error("option write not applied");
  a_pc_step: assert property (live && CORE_CTL.pc_inc && !CORE_REQ.valid |=>
    PROGRAM_COUNTER_LOW == $past(PROGRAM_COUNTER_LOW) + 8'h01)
    else $error("program counter did not step");
  a_flag_update: assert property (live && CORE_CTL.flags_we |=> STATUS_OUT[ST_Z] == $past(CORE_CTL.z) &&
    STATUS_OUT[ST_DC] == $past(CORE_CTL.dc) && STATUS_OUT[ST_C] == $past(CORE_CTL.c))
    else $error("ALU flags not taken into status");
  a_clear_hold: assert property (!MASTER_CLEAR_N [*3] |=> OPTION_OUT == OPTION_RST &&
    PROGRAM_COUNTER_LOW == PCL_RST && PORT_B_OE == 8'h00 && !CORE_RSP.valid)
    else $error("master clear did not reset control state");
  a_no_port_c: assert property ((VARIANT == DRF_VAR_SMALL || VARIANT == DRF_VAR_LARGE) |->
    PORT_C_OE == 8'h00 && PORT_C_OUT == 8'h00)
    else $error("absent port drives");
  c_read: cover property (CORE_RSP.valid);
  c_clkout: cover property ($rose(CYCLE_RATE_CLOCK_OUTPUT));
  c_clear: cover property (!MASTER_CLEAR_N [*3]);
endmodule

// File: drf_register_file.sv
// Data memory register file: special function and general purpose registers
`timescale 1ns/1ns

// Overview of operation
// - Data memory is one register file holding special and general groups.
// - Special group holds timer, program counter, status, ports and pointer.
// - Extra registers set port directions and prescaler options.
// - General registers hold data that instructions read and modify.
// - Small variant: 7 special, 25 general registers, no banks.
// - Extra port variant: 8 special and 24 general registers.
// - Large extra port variant: 8 special, 24 general, 48 banked.
// - Large variant: 7 special, 25 general, 48 banked general registers.
// - Low master clear input resets the control registers; data memory is kept.
// - In RC mode clock output runs at a quarter of the oscillator.
// - A dedicated input pin can clock the timer counter.
// - Every entry is reachable directly or through the pointer register.
module drf_register_file
#(
  parameter drf_pkg::drf_variant_t VARIANT = drf_pkg::DRF_VAR_SMALL
)
(
  // Clock and reset
  input  wire logic                             CLK,
  input  wire logic                             RST,
  // Device pins
  input  wire logic                             MASTER_CLEAR_N,
  input  wire logic                             RC_MODE,
  output logic                                  CYCLE_RATE_CLOCK_OUTPUT,
  output logic                                  CYCLE_ENABLE,
  input  wire logic                             TIMER_EXTERNAL_CLOCK_IN,
  // Port pins
  input  wire logic [drf_pkg::PORT_A_W-1:0]     PORT_A_IN,
  output logic      [drf_pkg::PORT_A_W-1:0]     PORT_A_OUT,
  output logic      [drf_pkg::PORT_A_W-1:0]     PORT_A_OE,
  input  wire logic [drf_pkg::DATA_W-1:0]       PORT_B_IN,
  output logic      [drf_pkg::DATA_W-1:0]       PORT_B_OUT,
  output logic      [drf_pkg::DATA_W-1:0]       PORT_B_OE,
  input  wire logic [drf_pkg::DATA_W-1:0]       PORT_C_IN,
  output logic      [drf_pkg::DATA_W-1:0]       PORT_C_OUT,
  output logic      [drf_pkg::DATA_W-1:0]       PORT_C_OE,
  // Core datapath
  input  wire drf_pkg::drf_req_t                CORE_REQ,
  input  wire drf_pkg::drf_core_ctl_t           CORE_CTL,
  input  wire drf_pkg::drf_cfg_t                CORE_CFG,
  output drf_pkg::drf_rsp_t                     CORE_RSP,
  output logic      [drf_pkg::DATA_W-1:0]       PROGRAM_COUNTER_LOW,
  output logic      [drf_pkg::DATA_W-1:0]       STATUS_OUT,
  output logic      [drf_pkg::DATA_W-1:0]       OPTION_OUT
);
  import drf_pkg::*;

  // Variant derived structure
  localparam logic HAS_PORT_C = (VARIANT == DRF_VAR_PORTC) || (VARIANT == DRF_VAR_LARGE_PORTC);
  localparam logic HAS_BANK   = (VARIANT == DRF_VAR_LARGE) || (VARIANT == DRF_VAR_LARGE_PORTC);
  localparam int   SFR_COUNT  = HAS_PORT_C ? SFR_PORTC : SFR_SMALL;
  localparam int   GPR_COUNT  = HAS_PORT_C ? GPR_PORTC : GPR_SMALL;
  localparam logic [DATA_W-1:0] PTR_FIXED = HAS_BANK ? PTR_FIXED_LARGE : PTR_FIXED_SMALL;

  typedef struct packed {
    logic                                master_clear_n_s1;
    logic                                master_clear_n_s2;
    logic                                tck_s1;
    logic                                tck_s2;
    logic                                tck_prev;
    logic [PORT_A_W-1:0]                 pa_s1;
    logic [PORT_A_W-1:0]                 pa_s2;
    logic [DATA_W-1:0]                   pb_s1;
    logic [DATA_W-1:0]                   pb_s2;
    logic [DATA_W-1:0]                   pc_s1;
    logic [DATA_W-1:0]                   pc_s2;
    logic [1:0]                          div;
    logic                                clkout;
    logic                                cycle_pulse;
    logic [DATA_W-1:0]                   timer;
    logic [DATA_W-1:0]                   pcl;
    logic [DATA_W-1:0]                   status;
    logic [DATA_W-1:0]                   pointer;
    logic [PORT_A_W-1:0]                 lat_a;
    logic [DATA_W-1:0]                   lat_b;
    logic [DATA_W-1:0]                   lat_c;
    logic [PORT_A_W-1:0]                 tris_a;
    logic [DATA_W-1:0]                   tris_b;
    logic [DATA_W-1:0]                   tris_c;
    logic [DATA_W-1:0]                   option;
    drf_rsp_t                            rsp;
    logic [GPR_SLOTS-1:0][DATA_W-1:0]    gpr;
  } drf_state_t;

  drf_state_t q;
  drf_state_t d;

  // Storage slot of a general register, MSB set when the address has one.
  // Bank 0 and the low half of every bank share the common slots, so the
  // common registers stay visible whatever the pointer's bank bits say.
  function automatic logic [SLOT_W:0] slot_of(logic [ADDR_W-1:0] a, logic [BANK_W-1:0] b);
    logic [SLOT_W-1:0] idx;
    logic              ok;
    idx = '0;
    ok  = 1'b0;
    if (a < ADR_PORT_C)
    begin
      ok = 1'b0;
    end
    else if (a == ADR_PORT_C && HAS_PORT_C)
    begin
      ok = 1'b0;
    end
    else if (HAS_BANK && a >= ADR_BANK_LO && b != '0)
    begin
      ok  = 1'b1;
      idx = SLOT_W'(GPR_SMALL) + SLOT_W'({b - 2'h1, 4'h0}) + SLOT_W'(a - ADR_BANK_LO);
    end
    else
    begin
      ok  = 1'b1;
      idx = SLOT_W'(a - ADR_PORT_C);
    end
    return {ok, idx};
  endfunction

  logic [ADDR_W-1:0] eff_addr;
  logic [BANK_W-1:0] eff_bank;
  logic [SLOT_W:0]   slot;
  logic              ext_edge;
  logic              tick;
  logic              do_wr;
  logic [DATA_W-1:0] rd_val;

  // Indirect access goes through the pointer; address zero is not a register
  always_comb
  begin
    eff_addr = (CORE_REQ.addr == ADR_INDIRECT) ? q.pointer[ADDR_W-1:0] : CORE_REQ.addr;
    eff_bank = HAS_BANK ? q.pointer[PTR_BANK_LSB +: BANK_W] : '0;
    slot     = slot_of(eff_addr, eff_bank);
  end

  // Timer source: synchronised pin edge or the instruction cycle enable
  always_comb
  begin
    ext_edge = q.option[OPT_EDGE] ? (q.tck_prev & ~q.tck_s2) : (~q.tck_prev & q.tck_s2);
    tick     = q.option[OPT_SRC] ? ext_edge : q.cycle_pulse;
    do_wr    = CORE_REQ.valid & CORE_REQ.write;
  end

  // Read multiplexer; port reads return the pin level, not the latch
  always_comb
  begin
    rd_val = '0;
    if (eff_addr == ADR_INDIRECT)
    begin
      rd_val = '0;
    end
    else if (eff_addr == ADR_TIMER)
    begin
      rd_val = q.timer;
    end
    else if (eff_addr == ADR_PCL)
    begin
      rd_val = q.pcl;
    end
    else if (eff_addr == ADR_STATUS)
    begin
      rd_val = q.status;
    end
    else if (eff_addr == ADR_POINTER)
    begin
      rd_val = q.pointer | PTR_FIXED;
    end
    else if (eff_addr == ADR_PORT_A)
    begin
      rd_val = {{(DATA_W-PORT_A_W){1'b0}}, q.pa_s2};
    end
    else if (eff_addr == ADR_PORT_B)
    begin
      rd_val = q.pb_s2;
    end
    else if (eff_addr == ADR_PORT_C && HAS_PORT_C)
    begin
      rd_val = q.pc_s2;
    end
    else if (slot[SLOT_W])
    begin
      rd_val = q.gpr[slot[SLOT_W-1:0]];
    end
  end

  always_comb
  begin
    d = q;
    // Two-stage synchronisers for every pin input except RC_MODE
    d.master_clear_n_s1  = MASTER_CLEAR_N;
    d.master_clear_n_s2  = q.master_clear_n_s1;
    d.tck_s1   = TIMER_EXTERNAL_CLOCK_IN;
    d.tck_s2   = q.tck_s1;
    d.tck_prev = q.tck_s2;
    d.pa_s1    = PORT_A_IN;
    d.pa_s2    = q.pa_s1;
    d.pb_s1    = PORT_B_IN;
    d.pb_s2    = q.pb_s1;
    d.pc_s1    = PORT_C_IN;
    d.pc_s2    = q.pc_s1;

    // Cycle rate divider: high for the last half of each four-clock cycle
    d.div         = q.div + 2'h1;
    d.clkout      = RC_MODE & d.div[CLKOUT_BIT];
    d.cycle_pulse = (q.div == DIV_LAST);

    // Hardware updates; a file write in the same cycle overrides them below
    if (tick)
    begin
      d.timer = q.timer + 8'h01;
    end
    if (CORE_CTL.pc_inc)
    begin
      d.pcl = q.pcl + 8'h01;
    end

    // File writes
    if (do_wr)
    begin
      if (eff_addr == ADR_TIMER)
      begin
        d.timer = CORE_REQ.wdata;
      end
      else if (eff_addr == ADR_PCL)
      begin
        d.pcl = CORE_REQ.wdata;
      end
      else if (eff_addr == ADR_STATUS)
      begin
        // Time-out and power-down bits are read only
        d.status = (q.status & ~ST_SW_MASK) | (CORE_REQ.wdata & ST_SW_MASK);
      end
      else if (eff_addr == ADR_POINTER)
      begin
        d.pointer = CORE_REQ.wdata & ~PTR_FIXED;
      end
      else if (eff_addr == ADR_PORT_A)
      begin
        d.lat_a = CORE_REQ.wdata[PORT_A_W-1:0];
      end
      else if (eff_addr == ADR_PORT_B)
      begin
        d.lat_b = CORE_REQ.wdata;
      end
      else if (eff_addr == ADR_PORT_C && HAS_PORT_C)
      begin
        d.lat_c = CORE_REQ.wdata;
      end
      else if (slot[SLOT_W])
      begin
        d.gpr[slot[SLOT_W-1:0]] = CORE_REQ.wdata;
      end
    end

    // Flag updates from the ALU take precedence over a file write to status
    if (CORE_CTL.flags_we)
    begin
      d.status[ST_Z]  = CORE_CTL.z;
      d.status[ST_DC] = CORE_CTL.dc;
      d.status[ST_C]  = CORE_CTL.c;
    end

    // Direction and option registers have their own strobes
    if (CORE_CFG.tris_we)
    begin
      if (CORE_CFG.tris_sel == SEL_PORT_A)
      begin
        d.tris_a = CORE_CFG.wdata[PORT_A_W-1:0];
      end
      else if (CORE_CFG.tris_sel == SEL_PORT_B)
      begin
        d.tris_b = CORE_CFG.wdata;
      end
      else if (CORE_CFG.tris_sel == SEL_PORT_C && HAS_PORT_C)
      begin
        d.tris_c = CORE_CFG.wdata;
      end
    end
    if (CORE_CFG.option_we)
    begin
      d.option = CORE_CFG.wdata;
    end

    // One-cycle read answer
    d.rsp.valid = CORE_REQ.valid & ~CORE_REQ.write;
    d.rsp.data  = CORE_REQ.valid & ~CORE_REQ.write ? rd_val : q.rsp.data;

    // Master clear: control registers return to reset, data memory is kept
    if (!q.master_clear_n_s2)
    begin
      d.timer     = TIMER_RST;
      d.pcl       = PCL_RST;
      d.status    = STATUS_RST;
      d.pointer   = POINTER_RST;
      d.option    = OPTION_RST;
      d.tris_a    = TRIS_RST[PORT_A_W-1:0];
      d.tris_b    = TRIS_RST;
      d.tris_c    = TRIS_RST;
      d.rsp.valid = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      q         <= '0;
      q.pcl     <= PCL_RST;
      q.status  <= STATUS_RST;
      q.option  <= OPTION_RST;
      q.tris_a  <= TRIS_RST[PORT_A_W-1:0];
      q.tris_b  <= TRIS_RST;
      q.tris_c  <= TRIS_RST;
    end
    else
    begin
      q <= d;
    end
  end

  // Outputs; a set direction bit means input, so the pin is not driven
  assign CYCLE_RATE_CLOCK_OUTPUT = q.clkout;
  assign CYCLE_ENABLE            = q.cycle_pulse;
  assign PORT_A_OUT              = q.lat_a;
  assign PORT_A_OE               = ~q.tris_a;
  assign PORT_B_OUT              = q.lat_b;
  assign PORT_B_OE               = ~q.tris_b;
  assign PORT_C_OUT              = HAS_PORT_C ? q.lat_c : '0;
  assign PORT_C_OE               = HAS_PORT_C ? ~q.tris_c : '0;
  assign CORE_RSP                = q.rsp;
  assign PROGRAM_COUNTER_LOW     = q.pcl;
  assign STATUS_OUT              = q.status;
  assign OPTION_OUT              = q.option;

endmodule

// File: testbench.sv
// Self-checking bench for the register file, large variant without port C
`timescale 1ns/1ns
module testbench;
  import drf_pkg::*;
  typedef struct packed {
    logic [4:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } drf_row_t;
  localparam drf_row_t ROWS [7] = '{'{5'h08, 8'h5A, 8'h5A}, '{5'h1F, 8'hC3, 8'hC3}, '{5'h07, 8'h3C, 8'h3C},
    '{5'h03, 8'h00, 8'h18}, '{5'h04, 8'h00, 8'h80}, '{5'h00, 8'h77, 8'h00}, '{5'h02, 8'h40, 8'h40}};
  logic clk, rst, master_clear_n_n, rc_mode, tmr_pin, clkout, cyc_en;
  logic [7:0] port_b_in, port_b_out, port_b_oe, pcl, status, option, q, prev;
  logic [3:0] port_a_in, port_a_out, port_a_oe;
  drf_req_t req;
  drf_core_ctl_t ctl;
  drf_cfg_t cfg;
  drf_rsp_t rsp;
  int fails, n_tests, rises;
  drf_register_file #(.VARIANT(DRF_VAR_LARGE)) dut (.CLK(clk), .RST(rst), .MASTER_CLEAR_N(master_clear_n_n),
    .RC_MODE(rc_mode), .CYCLE_RATE_CLOCK_OUTPUT(clkout), .CYCLE_ENABLE(cyc_en),
    .TIMER_EXTERNAL_CLOCK_IN(tmr_pin), .PORT_A_IN(port_a_in), .PORT_A_OUT(port_a_out), .PORT_A_OE(port_a_oe),
    .PORT_B_IN(port_b_in), .PORT_B_OUT(port_b_out), .PORT_B_OE(port_b_oe), .PORT_C_IN(8'h00),
    .PORT_C_OUT(), .PORT_C_OE(), .CORE_REQ(req), .CORE_CTL(ctl), .CORE_CFG(cfg), .CORE_RSP(rsp),
    .PROGRAM_COUNTER_LOW(pcl), .STATUS_OUT(status), .OPTION_OUT(option));
  drf_core_model core (.clk(clk), .req(req), .ctl(ctl), .cfg(cfg), .rsp(rsp));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    #200000;
    fails++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    master_clear_n_n = 1'b1;
    rc_mode = 1'b0;
    tmr_pin = 1'b0;
    port_b_in = 8'h96;
    port_a_in = 4'h9;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(pcl, PCL_RST);
    chk(status, STATUS_RST);
    chk(option, OPTION_RST);
    chk(port_b_oe, 8'h00);
    chk({4'h0, port_a_oe}, 8'h00);
    repeat (3) @(negedge clk);
    foreach (ROWS[i])
    begin
      core.access(1'b1, ROWS[i].a, ROWS[i].d, q);
      core.access(1'b0, ROWS[i].a, 8'h00, q);
      chk(q, ROWS[i].e);
    end
    core.pc_step();
    chk(pcl, 8'h41);
    // Same direct address in two banks must hold two values
    core.access(1'b1, ADR_POINTER, 8'h20, q);
    core.access(1'b1, 5'h10, 8'hA5, q);
    core.access(1'b1, ADR_POINTER, 8'h00, q);
    core.access(1'b1, 5'h10, 8'h11, q);
    core.access(1'b1, ADR_POINTER, 8'h30, q);
    core.access(1'b0, ADR_INDIRECT, 8'h00, q);
    chk(q, 8'hA5);
    core.access(1'b1, ADR_POINTER, 8'h10, q);
    core.access(1'b0, ADR_INDIRECT, 8'h00, q);
    chk(q, 8'h11);
    core.access(1'b0, ADR_PORT_B, 8'h00, q);
    chk(q, 8'h96);
    core.access(1'b1, ADR_PORT_B, 8'h3C, q);
    chk(port_b_out, 8'h3C);
    core.config_write(1'b1, SEL_PORT_B, 1'b0, 8'h0F);
    chk(port_b_oe, 8'hF0);
    core.access(1'b0, ADR_PORT_A, 8'h00, q);
    chk(q, 8'h09);
    core.access(1'b1, ADR_PORT_A, 8'hF6, q);
    chk({4'h0, port_a_out}, 8'h06);
    core.config_write(1'b1, SEL_PORT_A, 1'b0, 8'h03);
    chk({4'h0, port_a_oe}, 8'h0C);
    // Pin as timer source, rising edges first, then falling edges
    for (int m = 0; m < 2; m++)
    begin
      core.config_write(1'b0, 2'h0, 1'b1, (m != 0) ? 8'h3F : 8'h2F);
      chk(option, (m != 0) ? 8'h3F : 8'h2F);
      core.access(1'b1, ADR_TIMER, 8'h00, q);
      repeat (3)
      begin
        tmr_pin = 1'b1;
        repeat (2) @(negedge clk);
        tmr_pin = 1'b0;
        repeat (2) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      core.access(1'b0, ADR_TIMER, 8'h00, q);
      chk(q, 8'h03);
    end
    // Instruction cycle source: 40 clocks between write and read give 10 ticks whatever the phase
    core.config_write(1'b0, 2'h0, 1'b1, 8'h0F);
    core.access(1'b1, ADR_TIMER, 8'h00, q);
    repeat (39) @(negedge clk);
    core.access(1'b0, ADR_TIMER, 8'h00, q);
    chk(q, 8'h0A);
    rc_mode = 1'b1;
    repeat (8) @(negedge clk);
    prev = {7'h00, clkout};
    rises = 0;
    repeat (40)
    begin
      @(negedge clk);
      if (clkout && !prev[0])
        rises++;
      prev = {7'h00, clkout};
    end
    chk(8'(rises), 8'h0A);
    master_clear_n_n = 1'b0;
    repeat (5) @(negedge clk);
    master_clear_n_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(option, OPTION_RST);
    chk(port_b_oe, 8'h00);
    chk(pcl, PCL_RST);
    core.access(1'b0, 5'h08, 8'h00, q);
    chk(q, 8'h5A);
    // Flags beat the file write on their three bits; power bits stay read only
    core.flag_write(3'h5, ADR_STATUS, 8'hE2);
    chk(status, 8'hFD);
    core.flag_write(3'h2, ADR_INDIRECT, 8'h00);
    chk(status, 8'hFA);
    finish_test();
  end
endmodule
bind drf_register_file drf_properties #(.VARIANT(VARIANT)) u_props (.CLK(CLK), .RST(RST),
  .MASTER_CLEAR_N(MASTER_CLEAR_N), .RC_MODE(RC_MODE), .CYCLE_RATE_CLOCK_OUTPUT(CYCLE_RATE_CLOCK_OUTPUT),
  .CYCLE_ENABLE(CYCLE_ENABLE), .CORE_REQ(CORE_REQ), .CORE_CTL(CORE_CTL), .CORE_CFG(CORE_CFG),
  .CORE_RSP(CORE_RSP), .PROGRAM_COUNTER_LOW(PROGRAM_COUNTER_LOW), .OPTION_OUT(OPTION_OUT), .STATUS_OUT(STATUS_OUT),
  .PORT_B_OE(PORT_B_OE), .PORT_C_OUT(PORT_C_OUT), .PORT_C_OE(PORT_C_OE));
